// [logic/fmsp_pkg.sv]
// Shared constants and carrier types for the four-mode serial port
package fmsp_pkg;
  localparam logic [7:0] ADDR_CTRL_HIGH = 8'hEE;
  localparam logic [7:0] ADDR_CTRL_LOW = 8'hEF;
  localparam logic [7:0] ADDR_BAUD = 8'hED;
  localparam logic [7:0] ADDR_DATA = 8'hF0;
  localparam logic [7:0] CTRL_HIGH_RESET = 8'h00;
  localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam int MODE_LSB = 6;
  localparam int MPE_BIT = 5;
  localparam int RXEN_BIT = 4;
  localparam int TX9_BIT = 3;
  localparam int RX9_BIT = 2;
  localparam int RXIE_BIT = 1;
  localparam int RXPEND_BIT = 0;
  localparam int PARGEN_BIT = 7;
  localparam int PARODD_BIT = 6;
  localparam int TXIE_BIT = 1;
  localparam int TXPEND_BIT = 0;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_TICK = 4'h7;

  typedef enum logic [1:0] {
    FMSP_MODE_SHIFT = 2'h0,
    FMSP_MODE_ASYNC8 = 2'h1,
    FMSP_MODE_FIXED9 = 2'h2,
    FMSP_MODE_VAR9 = 2'h3
  } fmsp_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stopOk;
  } fmsp_rx_word_t;
endpackage

// [logic/fmsp_skid_buffer.sv]
// Two-entry valid/ready buffer for received words
`timescale 1ns/1ps
module fmsp_skid_buffer #(
  parameter int WIDTH = 10
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic inValid, // Word offered
  output logic inReady, // Room for a word
  input wire logic [WIDTH-1:0] inData, // Word in
  output logic outValid, // Word held
  input wire logic outReady, // Consumer takes word
  output logic [WIDTH-1:0] outData // Oldest word
);
  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end
  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic [1:0] count_ff, nxt_count;
  logic rdPtr_ff, nxt_rdPtr;
  logic wrPtr_ff, nxt_wrPtr;
  logic push, pop;

  assign inReady = (count_ff != 2'h2);
  assign outValid = (count_ff != 2'h0);
  assign outData = mem_ff[rdPtr_ff];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_wrPtr = wrPtr_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_mem[wrPtr_ff] = inData;
      nxt_wrPtr = ~wrPtr_ff;
    end
    if (pop) begin
      nxt_rdPtr = ~rdPtr_ff;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      count_ff <= 2'h0;
      rdPtr_ff <= 1'b0;
      wrPtr_ff <= 1'b0;
    end else begin
      mem_ff <= nxt_mem;
      count_ff <= nxt_count;
      rdPtr_ff <= nxt_rdPtr;
      wrPtr_ff <= nxt_wrPtr;
    end
  end

  bufCount_a: assert property (@(posedge sys_clk) disable iff (rst)
    count_ff <= 2'h2) else $error("buffer count out of range");
  bufFull_a: assert property (@(posedge sys_clk) disable iff (rst)
    (count_ff == 2'h2 && !outReady) |=> (count_ff == 2'h2))
    else $error("full buffer lost a word");
endmodule

// [logic/fmsp_rate_gen.sv]
// Oversample tick generator: divide by reload+1 or by one
`timescale 1ns/1ps
module fmsp_rate_gen #(
  parameter int RELOAD_W = 8
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic useReload, // Variable rate selected
  input wire logic [RELOAD_W-1:0] reload, // Baud reload value
  output logic tick // One pulse per sixteenth bit
);
  initial begin
    if (RELOAD_W < 1) $error("RELOAD_W must be positive");
  end
  logic [RELOAD_W-1:0] cnt_ff, nxt_cnt;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt = cnt_ff + 1'b1;
    if (!useReload || cnt_ff >= reload) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
  assign tick = tick_ff;

  fixedRate_a: assert property (@(posedge sys_clk) disable iff (rst)
    !useReload [*2] |-> tick) else $error("fixed rate tick missing"); // see R3
endmodule

// [logic/fmsp_serial_port.sv]
// Four-mode serial port: registers, transmitter and receiver
`timescale 1ns/1ps
// Function
// R1: Two-bit mode field picks shift, 8-bit async, fixed 9-bit or variable 9-bit.
// R2: Modes 0, 1 and 3 run at clock over sixteen times reload plus one.
// R3: Fixed 9-bit mode runs at clock over sixteen, reload ignored.
// R4: Start and stop bits frame the 8 or 9 data bits.
// R5: Address F0h writes transmit buffer and reads separate receive buffer.
// R6: Receiver double-buffered; unread byte lost when next completes. The code holds two unread words and drops the new one when full.
// R7: Any write to data address starts transmission. The code ignores writes while a frame is still being sent.
// R8: Shift mode receives only with pending clear and receive enabled.
// R9: Async modes receive on start bit while receive enabled.
// R10: Finished shift sets transmit or receive pending and raises interrupt.
// R11: Control high bit 1 gates the receive interrupt.
// R12: Control high bit 0 reads pending; software writes 0 to clear.
// R13: Multiprocessor enable in 9-bit modes drops frames with ninth bit 0.
// R14: Multiprocessor enable in 8-bit mode drops frames with bad stop bit.
// R15: Software keeps multiprocessor enable 0 in shift mode.
// R16: Control high bit 4 enables reception.
// R17: Bit 3 is transmitted ninth bit unless parity autogeneration is on.
// R18: Bit 2 captures received ninth bit unless parity autogeneration is on.
// R19: Reset clears control high register to 00h.
// R20: Receive pending at 8th shift bit, mid stop bit, or mid ninth bit.
// R21: Transmit pending at 8th shift bit or start of stop bit.
// R22: Control low bit 7 autogenerates the ninth transmitted parity bit.
// R23: LSB first, low start, high stop, line idles high.
// R24: Receiver samples at sixteen times rate, checks start, samples centres.
module fmsp_serial_port #(
  parameter int RELOAD_W = 8
) (
  input wire logic sys_clk, // Peripheral clock
  input wire logic rst, // Async reset
  input wire logic [7:0] regAddr, // Register address
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  input wire logic [7:0] regWdata, // Write data
  output logic [7:0] regRdata, // Read data, registered
  input wire logic receiveLine, // Serial input
  output logic transmitLine, // Serial output
  output logic shiftClock, // Shift clock in mode 0 transmit; stays high during mode 0 receive
  output logic rxIrq, // Receive interrupt request
  output logic txIrq // Transmit interrupt request
);
  initial begin
    if (RELOAD_W < 1 || RELOAD_W > 8) $error("RELOAD_W must be 1..8");
  end
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} fmsp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fmsp_rx_state_t;

  logic [7:0] ctrlHigh_ff, nxt_ctrlHigh;
  logic [7:0] ctrlLow_ff, nxt_ctrlLow;
  logic [RELOAD_W-1:0] baud_ff, nxt_baud;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rxIrq_ff, nxt_rxIrq, txIrq_ff, nxt_txIrq;
  fmsp_pkg::fmsp_mode_t mode;
  logic tick, wrHigh, wrLow, wrData, rdData, txDone, rxDone, rxKeep;

  assign mode = fmsp_pkg::fmsp_mode_t'(ctrlHigh_ff[fmsp_pkg::MODE_LSB +: 2]); // see R1
  assign wrHigh = regWrite && regAddr == fmsp_pkg::ADDR_CTRL_HIGH;
  assign wrLow = regWrite && regAddr == fmsp_pkg::ADDR_CTRL_LOW;
  assign wrData = regWrite && regAddr == fmsp_pkg::ADDR_DATA; // see R5
  assign rdData = regRead && regAddr == fmsp_pkg::ADDR_DATA;

  fmsp_rate_gen #(.RELOAD_W(RELOAD_W)) rateGen (
    .sys_clk(sys_clk),
    .rst(rst),
    .useReload(mode != fmsp_pkg::FMSP_MODE_FIXED9), // see R2, R3
    .reload(baud_ff),
    .tick(tick)
  );

  // Transmitter
  fmsp_tx_state_t txState_ff, nxt_txState;
  logic [3:0] txTick_ff, nxt_txTick;
  logic [3:0] txBit_ff, nxt_txBit;
  logic [8:0] txShift_ff, nxt_txShift;
  logic txLine_ff, nxt_txLine, sclk_ff, nxt_sclk;
  logic bitEnd, nineBit, txNinth;
  assign bitEnd = tick && txTick_ff == fmsp_pkg::OVERSAMPLE_LAST;
  assign nineBit = mode[1];
  assign txNinth = ctrlLow_ff[fmsp_pkg::PARGEN_BIT] ? // see R22, R17
    (^regWdata ^ ctrlLow_ff[fmsp_pkg::PARODD_BIT]) : ctrlHigh_ff[fmsp_pkg::TX9_BIT];

  always_comb begin
    nxt_txState = txState_ff;
    nxt_txTick = txTick_ff;
    nxt_txBit = txBit_ff;
    nxt_txShift = txShift_ff;
    nxt_txLine = txLine_ff;
    nxt_sclk = sclk_ff;
    txDone = 1'b0;
    if (tick) nxt_txTick = txTick_ff + 4'h1;
    unique case (txState_ff)
      TX_IDLE: begin
        nxt_txLine = 1'b1; // see R23
        nxt_sclk = 1'b1;
        if (wrData) begin // see R7
          nxt_txShift = {txNinth, regWdata};
          nxt_txTick = 4'h0;
          nxt_txBit = 4'h0;
          if (mode == fmsp_pkg::FMSP_MODE_SHIFT) begin
            nxt_txState = TX_DATA;
            nxt_txLine = regWdata[0];
          end else begin
            nxt_txState = TX_START;
            nxt_txLine = 1'b0; // see R4
          end
        end
      end
      TX_START: if (bitEnd) begin
        nxt_txState = TX_DATA;
        nxt_txLine = txShift_ff[0];
      end
      TX_DATA: begin
        if (mode == fmsp_pkg::FMSP_MODE_SHIFT && tick) nxt_sclk = ~txTick_ff[3];
        if (bitEnd) begin
          nxt_txShift = {1'b1, txShift_ff[8:1]};
          nxt_txBit = txBit_ff + 4'h1;
          nxt_txLine = txShift_ff[1];
          if (mode == fmsp_pkg::FMSP_MODE_SHIFT && txBit_ff == 4'h7) begin
            nxt_txState = TX_IDLE;
            nxt_txLine = 1'b1;
            txDone = 1'b1; // see R21
          end else if (txBit_ff == (nineBit ? 4'h8 : 4'h7)) begin
            nxt_txState = TX_STOP;
            nxt_txLine = 1'b1;
            txDone = 1'b1; // see R21
          end
        end
      end
      TX_STOP: if (bitEnd) nxt_txState = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txState_ff <= TX_IDLE;
      txTick_ff <= 4'h0;
      txBit_ff <= 4'h0;
      txShift_ff <= 9'h1FF;
      txLine_ff <= 1'b1;
      sclk_ff <= 1'b1;
    end else begin
      txState_ff <= nxt_txState;
      txTick_ff <= nxt_txTick;
      txBit_ff <= nxt_txBit;
      txShift_ff <= nxt_txShift;
      txLine_ff <= nxt_txLine;
      sclk_ff <= nxt_sclk;
    end
  end

  // Receiver
  fmsp_rx_state_t rxState_ff, nxt_rxState;
  logic [3:0] rxTick_ff, nxt_rxTick;
  logic [3:0] rxBit_ff, nxt_rxBit;
  logic [8:0] rxShift_ff, nxt_rxShift;
  logic sampleNow, lastBit, rxEnable, bufInReady, bufOutValid;
  fmsp_pkg::fmsp_rx_word_t rxWord, bufWord;
  assign sampleNow = tick && rxTick_ff == fmsp_pkg::SAMPLE_TICK; // see R24
  assign rxEnable = ctrlHigh_ff[fmsp_pkg::RXEN_BIT]; // see R16
  assign lastBit = rxBit_ff == (nineBit ? 4'h8 : 4'h7);

  always_comb begin
    nxt_rxState = rxState_ff;
    nxt_rxTick = rxTick_ff;
    nxt_rxBit = rxBit_ff;
    nxt_rxShift = rxShift_ff;
    rxDone = 1'b0;
    rxWord = '0;
    if (tick) nxt_rxTick = rxTick_ff + 4'h1;
    unique case (rxState_ff)
      RX_IDLE: begin
        nxt_rxTick = 4'h0;
        nxt_rxBit = 4'h0;
        if (mode == fmsp_pkg::FMSP_MODE_SHIFT) begin
          if (rxEnable && !ctrlHigh_ff[fmsp_pkg::RXPEND_BIT] && txState_ff == TX_IDLE)
            nxt_rxState = RX_DATA; // see R8
        end else if (rxEnable && !receiveLine) begin
          nxt_rxState = RX_START; // see R9
        end
      end
      RX_START: if (sampleNow) begin
        if (receiveLine) nxt_rxState = RX_IDLE; // see R24
      end else if (tick && rxTick_ff == fmsp_pkg::OVERSAMPLE_LAST) begin
        nxt_rxState = RX_DATA;
      end
      RX_DATA: begin
        if (sampleNow) begin
          nxt_rxShift = {receiveLine, rxShift_ff[8:1]}; // see R23
          nxt_rxBit = rxBit_ff + 4'h1;
          if (mode == fmsp_pkg::FMSP_MODE_SHIFT && rxBit_ff == 4'h7) begin
            nxt_rxState = RX_IDLE;
            rxDone = 1'b1; // see R20
            rxWord = '{data: {receiveLine, rxShift_ff[8:2]}, ninth: 1'b0, stopOk: 1'b1};
          end else if (lastBit && nineBit) begin
            nxt_rxState = RX_STOP;
            rxDone = 1'b1; // see R20
            rxWord = '{data: rxShift_ff[8:1], ninth: receiveLine, stopOk: 1'b1};
          end
        end
        // The count has already passed the last bit when its sample was taken
        if (tick && rxTick_ff == fmsp_pkg::OVERSAMPLE_LAST && rxBit_ff == 4'h8 && !nineBit
            && mode != fmsp_pkg::FMSP_MODE_SHIFT)
          nxt_rxState = RX_STOP;
      end
      RX_STOP: if (sampleNow) begin
        nxt_rxState = RX_IDLE;
        if (!nineBit) begin
          rxDone = 1'b1; // see R20
          rxWord = '{data: rxShift_ff[8:1], ninth: receiveLine, stopOk: receiveLine};
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxState_ff <= RX_IDLE;
      rxTick_ff <= 4'h0;
      rxBit_ff <= 4'h0;
      rxShift_ff <= 9'h000;
    end else begin
      rxState_ff <= nxt_rxState;
      rxTick_ff <= nxt_rxTick;
      rxBit_ff <= nxt_rxBit;
      rxShift_ff <= nxt_rxShift;
    end
  end

  // Address filter for multiprocessor links
  assign rxKeep = !(ctrlHigh_ff[fmsp_pkg::MPE_BIT] && ( // see R13, R14
    (nineBit && !rxWord.ninth) ||
    (mode == fmsp_pkg::FMSP_MODE_ASYNC8 && !rxWord.stopOk)));

  // When full, a new word is dropped: the older bytes survive
  fmsp_skid_buffer #(.WIDTH($bits(fmsp_pkg::fmsp_rx_word_t))) rxBuf (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(rxDone && rxKeep), // see R6
    .inReady(bufInReady),
    .inData(rxWord),
    .outValid(bufOutValid),
    .outReady(rdData),
    .outData(bufWord)
  );

  // Register file
  always_comb begin
    nxt_ctrlHigh = ctrlHigh_ff;
    nxt_ctrlLow = ctrlLow_ff;
    nxt_baud = baud_ff;
    nxt_rdata = rdata_ff;
    if (wrHigh) begin
      nxt_ctrlHigh = regWdata;
      // Pending can only be cleared by software, never set
      nxt_ctrlHigh[fmsp_pkg::RXPEND_BIT] = ctrlHigh_ff[fmsp_pkg::RXPEND_BIT]
        & regWdata[fmsp_pkg::RXPEND_BIT]; // see R12
    end
    if (wrLow) begin
      nxt_ctrlLow = regWdata;
      nxt_ctrlLow[fmsp_pkg::TXPEND_BIT] = ctrlLow_ff[fmsp_pkg::TXPEND_BIT]
        & regWdata[fmsp_pkg::TXPEND_BIT];
    end
    if (regWrite && regAddr == fmsp_pkg::ADDR_BAUD) nxt_baud = regWdata[RELOAD_W-1:0];
    // Hardware set wins over a simultaneous software clear
    if (rxDone && rxKeep) nxt_ctrlHigh[fmsp_pkg::RXPEND_BIT] = 1'b1; // see R10
    if (rxDone && rxKeep && nineBit && !ctrlLow_ff[fmsp_pkg::PARGEN_BIT])
      nxt_ctrlHigh[fmsp_pkg::RX9_BIT] = rxWord.ninth; // see R18
    if (txDone) nxt_ctrlLow[fmsp_pkg::TXPEND_BIT] = 1'b1; // see R10
    if (regRead) begin
      unique case (regAddr)
        fmsp_pkg::ADDR_CTRL_HIGH: nxt_rdata = ctrlHigh_ff;
        fmsp_pkg::ADDR_CTRL_LOW: nxt_rdata = ctrlLow_ff;
        fmsp_pkg::ADDR_BAUD: nxt_rdata = 8'(baud_ff);
        fmsp_pkg::ADDR_DATA: nxt_rdata = bufOutValid ? bufWord.data : 8'h00; // see R5
        default: nxt_rdata = 8'h00;
      endcase
    end
    nxt_rxIrq = nxt_ctrlHigh[fmsp_pkg::RXPEND_BIT] && nxt_ctrlHigh[fmsp_pkg::RXIE_BIT]; // see R11
    nxt_txIrq = nxt_ctrlLow[fmsp_pkg::TXPEND_BIT] && nxt_ctrlLow[fmsp_pkg::TXIE_BIT];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrlHigh_ff <= fmsp_pkg::CTRL_HIGH_RESET; // see R19
      ctrlLow_ff <= fmsp_pkg::CTRL_LOW_RESET;
      baud_ff <= RELOAD_W'(fmsp_pkg::BAUD_RESET);
      rdata_ff <= 8'h00;
      rxIrq_ff <= 1'b0;
      txIrq_ff <= 1'b0;
    end else begin
      ctrlHigh_ff <= nxt_ctrlHigh;
      ctrlLow_ff <= nxt_ctrlLow;
      baud_ff <= nxt_baud;
      rdata_ff <= nxt_rdata;
      rxIrq_ff <= nxt_rxIrq;
      txIrq_ff <= nxt_txIrq;
    end
  end

  assign regRdata = rdata_ff;
  assign transmitLine = txLine_ff;
  assign shiftClock = sclk_ff;
  assign rxIrq = rxIrq_ff;
  assign txIrq = txIrq_ff;

  // Checks
  sequence rxFinish_s;
    rxDone && rxKeep;
  endsequence
  rxPendSet_a: assert property (@(posedge sys_clk) disable iff (rst)
    rxFinish_s |=> ctrlHigh_ff[fmsp_pkg::RXPEND_BIT]) else $error("rx pending not set"); // see R10
  txPendSet_a: assert property (@(posedge sys_clk) disable iff (rst)
    txDone |=> ctrlLow_ff[fmsp_pkg::TXPEND_BIT]) else $error("tx pending not set"); // see R21
  rxIrqGate_a: assert property (@(posedge sys_clk) disable iff (rst)
    rxIrq |-> ctrlHigh_ff[fmsp_pkg::RXIE_BIT] && ctrlHigh_ff[fmsp_pkg::RXPEND_BIT])
    else $error("rx interrupt without enable"); // see R11
  pendClear_a: assert property (@(posedge sys_clk) disable iff (rst)
    wrHigh && !regWdata[fmsp_pkg::RXPEND_BIT] && !rxDone |=>
    !ctrlHigh_ff[fmsp_pkg::RXPEND_BIT]) else $error("pending not cleared"); // see R12
  txStart_a: assert property (@(posedge sys_clk) disable iff (rst)
    wrData && txState_ff == TX_IDLE |=> txState_ff != TX_IDLE) else $error("no tx start"); // see R7
  startLow_a: assert property (@(posedge sys_clk) disable iff (rst)
    txState_ff == TX_START |-> !transmitLine) else $error("start bit not low"); // see R4
  rxDisabled_a: assert property (@(posedge sys_clk) disable iff (rst)
    rxState_ff == RX_IDLE && !rxEnable |=> rxState_ff == RX_IDLE)
    else $error("receive while disabled"); // see R16
  mpFilter_a: assert property (@(posedge sys_clk) disable iff (rst)
    rxDone && nineBit && ctrlHigh_ff[fmsp_pkg::MPE_BIT] && !rxWord.ninth
    && !ctrlHigh_ff[fmsp_pkg::RXPEND_BIT] && !wrHigh |=> !ctrlHigh_ff[fmsp_pkg::RXPEND_BIT])
    else $error("address filter failed"); // see R13
  idleHigh_a: assert property (@(posedge sys_clk) disable iff (rst)
    txState_ff == TX_IDLE && !$past(wrData) |-> transmitLine) else $error("idle not high"); // see R23
endmodule

// [sim/fmsp_remote_peer.sv]
// Remote asynchronous transceiver facing the serial port
`timescale 1ns/1ps
module fmsp_remote_peer (
  input wire logic sys_clk, // Clock
  input wire logic transmitLine, // Line from the port
  output logic receiveLine // Line into the port
);
  initial receiveLine = 1'h1;

  task automatic send_bit(input logic b, input int bitLen);
    @(posedge sys_clk);
    receiveLine <= b;
    repeat (bitLen - 1) @(posedge sys_clk);
  endtask

  // Low start, data LSB first, stop level, then the line rests high
  task automatic send_frame(input logic [8:0] word, input int nBits, input logic stopLvl,
      input int bitLen);
    int i;
    send_bit(1'h0, bitLen);
    for (i = 0; i < nBits; i++) begin
      send_bit(word[i], bitLen);
    end
    send_bit(stopLvl, bitLen);
    @(posedge sys_clk);
    receiveLine <= 1'h1;
  endtask

  // Samples start, data and stop at bit centres; bit 0 of the result is the start bit
  task automatic capture(input int nBits, input int bitLen, output logic [10:0] frameBits);
    int i;
    frameBits = 11'h000;
    @(negedge transmitLine);
    repeat (bitLen / 2) @(posedge sys_clk);
    for (i = 0; i < nBits + 2; i++) begin
      frameBits[i] = transmitLine;
      repeat (bitLen) @(posedge sys_clk);
    end
  endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
module testbench;
  logic sys_clk;
  logic rst;
  logic [7:0] regAddr;
  logic regWrite;
  logic regRead;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic receiveLine;
  logic transmitLine;
  logic shiftClock;
  logic rxIrq;
  logic txIrq;
  int numErrors = 0;
  int numChecks = 0;

  fmsp_serial_port u_fmsp_serial_port (
    .sys_clk(sys_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regRead(regRead),
    .regWdata(regWdata),
    .regRdata(regRdata),
    .receiveLine(receiveLine),
    .transmitLine(transmitLine),
    .shiftClock(shiftClock),
    .rxIrq(rxIrq),
    .txIrq(txIrq)
  );

  fmsp_remote_peer u_peer (
    .sys_clk(sys_clk),
    .transmitLine(transmitLine),
    .receiveLine(receiveLine)
  );

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge sys_clk);
    regWrite <= 1'h0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge sys_clk);
    regRead <= 1'h0;
    @(posedge sys_clk);
    d = regRdata;
  endtask

  task automatic t_reset;
    logic [7:0] d;
    check(11'(transmitLine), 11'h001, "idle line");
    reg_read(fmsp_pkg::ADDR_CTRL_HIGH, d);
    check(11'(d), 11'h000, "control high reset");
    reg_write(8'h10, 8'h5A);
    reg_read(8'h10, d);
    check(11'(d), 11'h000, "unmapped read");
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'(d), 11'h000, "empty receive buffer");
  endtask

  task automatic t_shift;
    logic [7:0] d;
    logic prev;
    int i;
    int falls;
    falls = 0;
    prev = 1'h1;
    reg_write(fmsp_pkg::ADDR_BAUD, 8'h00);
    reg_write(fmsp_pkg::ADDR_CTRL_LOW, 8'h02);
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'h00);
    reg_write(fmsp_pkg::ADDR_DATA, 8'h5A);
    // Sampled on the falling edge, where the registered outputs have settled
    for (i = 0; i < 400 && txIrq !== 1'h1; i++) begin
      @(negedge sys_clk);
      if (prev === 1'h1 && shiftClock === 1'h0) falls++;
      prev = shiftClock;
    end
    check(11'(txIrq), 11'h001, "shift transmit done");
    check(11'(falls), 11'h008, "shift clock pulses");
    reg_write(fmsp_pkg::ADDR_CTRL_LOW, 8'h02);
    reg_read(fmsp_pkg::ADDR_CTRL_LOW, d);
    check(11'(d), 11'h002, "tx pending cleared");
  endtask

  // Shift-mode receive of an idle-high line gives all ones, then waits for a clear
  task automatic t_shift_rx;
    logic [7:0] d;
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'h12);
    repeat (200) @(posedge sys_clk);
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'({rxIrq, d}), 11'h1FF, "shift receive");
    repeat (200) @(posedge sys_clk);
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'(d), 11'h000, "no receive while pending");
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'h00);
  endtask

  task automatic t_tx(input logic [1:0] mode, input logic [7:0] rel, input logic tx9,
      input logic pg, input int bitLen);
    logic [10:0] got;
    logic [7:0] d;
    logic ninth;
    ninth = pg ? ^8'hA5 : tx9;
    reg_write(fmsp_pkg::ADDR_BAUD, rel);
    reg_write(fmsp_pkg::ADDR_CTRL_LOW, {pg, 7'h02});
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, {mode, 2'h0, tx9, 3'h0});
    fork
      u_peer.capture(mode[1] ? 9 : 8, bitLen, got);
      reg_write(fmsp_pkg::ADDR_DATA, 8'hA5);
    join
    check(got, mode[1] ? {1'h1, ninth, 8'hA5, 1'h0} : {2'h1, 8'hA5, 1'h0}, "frame");
    check(11'(txIrq), 11'h001, "tx irq");
    reg_read(fmsp_pkg::ADDR_CTRL_LOW, d);
    check(11'(d), 11'({pg, 7'h03}), "tx pending");
    reg_write(fmsp_pkg::ADDR_CTRL_LOW, {pg, 7'h02});
    reg_read(fmsp_pkg::ADDR_CTRL_LOW, d);
    check(11'({txIrq, d}), 11'({1'h0, pg, 7'h02}), "tx clear");
  endtask

  task automatic t_rx;
    logic [7:0] d;
    reg_write(fmsp_pkg::ADDR_BAUD, 8'h01);
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'h52);
    u_peer.send_frame(9'h03C, 8, 1'h1, 32);
    u_peer.send_frame(9'h0C3, 8, 1'h1, 32);
    u_peer.send_frame(9'h0E1, 8, 1'h1, 32);
    check(11'(rxIrq), 11'h001, "rx irq");
    reg_read(fmsp_pkg::ADDR_CTRL_HIGH, d);
    check(11'(d), 11'h053, "rx pending");
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'(d), 11'h03C, "first byte");
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'(d), 11'h0C3, "second byte");
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'(d), 11'h000, "third byte lost");
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'h51);
    reg_read(fmsp_pkg::ADDR_CTRL_HIGH, d);
    check(11'({rxIrq, d}), 11'h051, "rx irq gated");
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'h50);
    reg_read(fmsp_pkg::ADDR_CTRL_HIGH, d);
    check(11'(d), 11'h050, "rx pending cleared");
  endtask

  task automatic t_mce;
    logic [7:0] d;
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'hF2);
    u_peer.send_frame(9'h011, 9, 1'h1, 32);
    reg_read(fmsp_pkg::ADDR_CTRL_HIGH, d);
    check(11'({rxIrq, d[0]}), 11'h000, "address frame filtered");
    u_peer.send_frame(9'h122, 9, 1'h1, 32);
    reg_read(fmsp_pkg::ADDR_CTRL_HIGH, d);
    check(11'({rxIrq, d[2], d[0]}), 11'h007, "ninth bit kept");
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'(d), 11'h022, "only accepted frame stored");
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'hE2);
    u_peer.send_frame(9'h133, 9, 1'h1, 32);
    reg_read(fmsp_pkg::ADDR_DATA, d);
    check(11'(d), 11'h000, "receiver disabled");
    // Kept last: a low stop level can look like a new start bit afterwards
    reg_write(fmsp_pkg::ADDR_CTRL_HIGH, 8'h72);
    u_peer.send_frame(9'h055, 8, 1'h0, 32);
    reg_read(fmsp_pkg::ADDR_CTRL_HIGH, d);
    check(11'({rxIrq, d[0]}), 11'h000, "bad stop filtered");
  endtask

  initial begin
    #100000;
    numErrors++;
    $display("unexpected at %0t: run did not finish in time", $time);
    give_verdict;
  end

  initial begin
    rst = 1'h1;
    regAddr = 8'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
    regWdata = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    t_reset;
    t_shift;
    t_shift_rx;
    t_tx(2'h1, 8'h01, 1'h0, 1'h0, 32);
    t_tx(2'h2, 8'h01, 1'h1, 1'h0, 16);
    t_tx(2'h3, 8'h02, 1'h1, 1'h1, 48);
    t_tx(2'h3, 8'h00, 1'h0, 1'h0, 16);
    t_rx;
    t_mce;
    give_verdict;
  end
endmodule
